// ---- vrc_capture.sv ----
// Video region-of-interest capture channel with ping-pong and ring-buffer DMA
`timescale 1ns/1ps

module vrc_capture
    import vrc_pkg::*;
#(
    parameter int CW = 16
) (
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Digitizer channel 0
    input  wire logic [7:0]  ch0Red,
    input  wire logic [7:0]  ch0Green,
    input  wire logic [7:0]  ch0Blue,
    input  wire logic        ch0Hsync,
    input  wire logic        ch0Vsync,
    // Digitizer channel 1
    input  wire logic [7:0]  ch1Red,
    input  wire logic [7:0]  ch1Green,
    input  wire logic [7:0]  ch1Blue,
    input  wire logic        ch1Hsync,
    input  wire logic        ch1Vsync,
    // Digitizer input mux settings
    output logic      [1:0]  muxSel0,
    output logic      [1:0]  muxSel1,
    output logic             activeChan,
    // DMA write stream
    output logic             dmaValid,
    output logic      [31:0] dmaAddr,
    output logic      [23:0] dmaData,
    output logic      [1:0]  dmaBytes,
    output logic             dmaInCrop
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0] ctrlQ, hroiQ, vroiQ, ringQ, baseQ, strideQ, cropXyQ, cropWhQ;
    logic [3:0]  muxQ;
    logic        ackQ;
    logic [31:0] datQ;
    logic        wbWrite;
    vrc_state_t  stateQ;
    logic        activeChanQ;
    logic [1:0]  syncQ, syncPrevQ;
    logic [1:0]  syncHighShort;
    logic [7:0]  redQ, greenQ, blueQ;
    logic        hPol, vPol, hAct, hActPrev, vAct, vActPrev, hLead, vLead;
    logic [CW-1:0] pixCntQ, lineCntQ, lineLenQ, pixIdx, rowQ, col;
    logic        fieldQ, fieldD;
    logic [3:0]  bufIdxQ, bufIdxNext;
    logic [15:0] frameCntQ;
    logic [31:0] linAddrQ, bufBytes, bufAddr, lineStart, colBytes;
    logic [CW-1:0] rowAddr, rowAddrNext, lineRel, frameRow;
    logic        capOk, inLine, inPix, pixWr, lineDone, frameDone, startFrame;
    logic        dmaValidQ, dmaInCropQ;
    logic [31:0] dmaAddrQ;
    logic [23:0] dmaDataQ;
    logic [1:0]  dmaBytesQ;

    // Configuration fields
    logic [1:0]    chanEn;
    logic          capEn, autoPol, interlace, mono, linear, ppChan, ppMux;
    logic [CW-1:0] startPix, roiWidth, startLine, endLine, linesPerBuf;
    logic [CW-1:0] cropX, cropY, cropW, cropH;
    logic [3:0]    ringCount;

    assign chanEn      = ctrlQ[CTRL_EN0 +: 2];
    assign capEn       = ctrlQ[CTRL_CAPEN];
    assign autoPol     = ctrlQ[CTRL_AUTOPOL];
    assign interlace   = ctrlQ[CTRL_INTERLACE];
    assign mono        = ctrlQ[CTRL_MONO];
    assign linear      = ctrlQ[CTRL_LINEAR];
    assign ppChan      = ctrlQ[CTRL_PPCHAN];
    assign ppMux       = ctrlQ[CTRL_PPMUX];
    assign startPix    = hroiQ[15:0];
    assign roiWidth    = hroiQ[31:16];
    assign startLine   = vroiQ[15:0];
    assign endLine     = vroiQ[31:16];
    assign ringCount   = ringQ[3:0];
    assign linesPerBuf = ringQ[31:16];
    assign cropX       = cropXyQ[15:0];
    assign cropY       = cropXyQ[31:16];
    assign cropW       = cropWhQ[15:0];
    assign cropH       = cropWhQ[31:16];

    // Byte-lane merge for partial writes
    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                               input logic [31:0] wr,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------------
    // Ack one cycle after request, dropped the next; write lands on ack edge
    assign wbWrite = cyc_i & stb_i & we_i & ackQ;

    always_ff @(posedge clk) begin
        if (rst) begin
            ackQ <= 1'b0;
        end else begin
            ackQ <= cyc_i & stb_i & ~ackQ;
        end
    end

    // Read data; unmapped offsets read as zero
    always_ff @(posedge clk) begin
        if (rst) begin
            datQ <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~ackQ) begin
            case (adr_i)
                REG_CTRL:   datQ <= ctrlQ;
                REG_HROI:   datQ <= hroiQ;
                REG_VROI:   datQ <= vroiQ;
                REG_RING:   datQ <= ringQ;
                REG_BASE:   datQ <= baseQ;
                REG_STRIDE: datQ <= strideQ;
                REG_CROPXY: datQ <= cropXyQ;
                REG_CROPWH: datQ <= cropWhQ;
                REG_MUX:    datQ <= {28'h000_0000, muxQ};
                REG_STATUS: datQ <= {frameCntQ, 8'h00, bufIdxQ, fieldQ,
                                     syncHighShort, activeChanQ};
                default:    datQ <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration registers, kept intact while capture is paused
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrlQ   <= CTRL_RST;
            hroiQ   <= HROI_RST;
            vroiQ   <= VROI_RST;
            ringQ   <= RING_RST;
            baseQ   <= BASE_RST;
            strideQ <= STRIDE_RST;
            cropXyQ <= CROPXY_RST;
            cropWhQ <= CROPWH_RST;
        end else if (wbWrite) begin
            case (adr_i)
                REG_CTRL:   ctrlQ   <= mergeBytes(ctrlQ, dat_i, sel_i);
                REG_HROI:   hroiQ   <= mergeBytes(hroiQ, dat_i, sel_i);
                REG_VROI:   vroiQ   <= mergeBytes(vroiQ, dat_i, sel_i);
                REG_RING:   ringQ   <= mergeBytes(ringQ, dat_i, sel_i);
                REG_BASE:   baseQ   <= mergeBytes(baseQ, dat_i, sel_i);
                REG_STRIDE: strideQ <= mergeBytes(strideQ, dat_i, sel_i);
                REG_CROPXY: cropXyQ <= mergeBytes(cropXyQ, dat_i, sel_i);
                REG_CROPWH: cropWhQ <= mergeBytes(cropWhQ, dat_i, sel_i);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Input stage and sync polarity
    // ------------------------------------------------------------------
    // Register the selected channel's pixel and syncs
    always_ff @(posedge clk) begin
        if (rst) begin
            syncQ     <= 2'b00;
            syncPrevQ <= 2'b00;
            redQ      <= 8'h00;
            greenQ    <= 8'h00;
            blueQ     <= 8'h00;
        end else begin
            syncQ     <= activeChanQ ? {ch1Vsync, ch1Hsync} : {ch0Vsync, ch0Hsync};
            syncPrevQ <= syncQ;
            redQ      <= activeChanQ ? ch1Red   : ch0Red;
            greenQ    <= activeChanQ ? ch1Green : ch0Green;
            blueQ     <= activeChanQ ? ch1Blue  : ch0Blue;
        end
    end

    // Auto polarity: the level held for the shorter run is the active one
    for (genvar g = 0; g < 2; g++) begin : gPolDet
        logic [CW-1:0] runCntQ, hiRunQ, loRunQ;
        always_ff @(posedge clk) begin
            if (rst) begin
                runCntQ <= '0;
                hiRunQ  <= '0;
                loRunQ  <= '0;
            end else if (syncQ[g] != syncPrevQ[g]) begin
                if (syncPrevQ[g]) begin
                    hiRunQ <= runCntQ;
                end else begin
                    loRunQ <= runCntQ;
                end
                runCntQ <= '0;
            end else if (runCntQ != '1) begin
                runCntQ <= runCntQ + 1'b1;
            end
        end
        assign syncHighShort[g] = hiRunQ < loRunQ;
    end

    // Polarity choice; the two manual selects have opposite sense
    assign hPol = autoPol ? syncHighShort[0] : ctrlQ[CTRL_HSHIGH];
    assign vPol = autoPol ? syncHighShort[1] : ~ctrlQ[CTRL_VSLOW];
    assign hAct     = hPol ? syncQ[0] : ~syncQ[0];
    assign hActPrev = hPol ? syncPrevQ[0] : ~syncPrevQ[0];
    assign vAct     = vPol ? syncQ[1] : ~syncQ[1];
    assign vActPrev = vPol ? syncPrevQ[1] : ~syncPrevQ[1];
    assign hLead    = hAct & ~hActPrev;
    assign vLead    = vAct & ~vActPrev;

    // ------------------------------------------------------------------
    // Pixel, line and field counting
    // ------------------------------------------------------------------
    // Pixel on the hsync leading edge has index zero
    assign pixIdx = hLead ? '0 : pixCntQ + 1'b1;
    // A vsync landing past mid-line marks the odd field
    assign fieldD = interlace & (pixCntQ > (lineLenQ >> 1));

    always_ff @(posedge clk) begin
        if (rst) begin
            pixCntQ  <= '0;
            lineCntQ <= '0;
            lineLenQ <= '0;
            fieldQ   <= 1'b0;
        end else begin
            pixCntQ <= pixIdx;
            if (hLead) begin
                lineLenQ <= pixCntQ;
            end
            if (vLead) begin
                lineCntQ <= '0;
                fieldQ   <= fieldD;
            end else if (hLead) begin
                lineCntQ <= lineCntQ + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Capture window and sequencing
    // ------------------------------------------------------------------
    assign capOk      = capEn & chanEn[activeChanQ];
    assign inLine     = (lineCntQ >= startLine) && (lineCntQ <= endLine);
    assign inPix      = (pixIdx >= startPix) && (pixIdx < CW'(startPix + roiWidth));
    assign pixWr      = (stateQ == ST_CAPT) && capOk && inLine && inPix;
    assign lineDone   = hLead && (stateQ == ST_CAPT) && inLine;
    assign frameDone  = lineDone && (lineCntQ == endLine) && (!interlace || fieldQ);
    // Interlaced frames always begin on the even field
    assign startFrame = (stateQ == ST_WAIT) && capOk && vLead && !fieldD;

    // Sequencer; waits on the current channel until a frame arrives
    always_ff @(posedge clk) begin
        if (rst) begin
            stateQ <= ST_WAIT;
        end else begin
            case (stateQ)
                ST_WAIT: begin
                    if (startFrame) begin
                        stateQ <= ST_CAPT;
                    end
                end
                ST_CAPT: begin
                    if (!capOk) begin
                        stateQ <= ST_WAIT;
                    end else if (frameDone) begin
                        stateQ <= ST_SWITCH;
                    end
                end
                ST_SWITCH: stateQ <= ST_WAIT;
                default:   stateQ <= ST_WAIT;
            endcase
        end
    end

    // Ping-pong: leave the channel after a whole frame, or in ST_WAIT once it is disabled, so the
    // mux relock of the left channel overlaps capture on the other
    always_ff @(posedge clk) begin
        if (rst) begin
            activeChanQ <= 1'b0;
            muxQ        <= {MUX_A, MUX_A};
        end else begin
            if (wbWrite && adr_i == REG_MUX && sel_i[0]) begin
                muxQ <= dat_i[3:0];
            end
            if (stateQ == ST_SWITCH) begin
                if (ppMux && muxQ[{activeChanQ, 1'b0} +: 2] != MUX_OFF) begin
                    muxQ[{activeChanQ, 1'b0} +: 2] <=
                        (muxQ[{activeChanQ, 1'b0} +: 2] == MUX_A) ? MUX_B : MUX_A;
                end
                if (ppChan && chanEn[~activeChanQ]) begin
                    activeChanQ <= ~activeChanQ;
                end
            end else if (stateQ == ST_WAIT && !chanEn[activeChanQ] && chanEn[~activeChanQ]) begin
                activeChanQ <= ~activeChanQ;
            end
        end
    end

    // ------------------------------------------------------------------
    // Buffer ring and addressing
    // ------------------------------------------------------------------
    assign bufIdxNext  = (bufIdxQ + 1'b1 >= ringCount) ? 4'h0 : bufIdxQ + 1'b1;
    assign bufBytes    = 32'(linesPerBuf) * strideQ;
    assign bufAddr     = baseQ + 32'(bufIdxQ) * bufBytes;
    // Interlaced fields interleave their lines in the buffer
    assign rowAddr     = interlace ? {rowQ[CW-2:0], fieldQ} : rowQ;
    assign rowAddrNext = CW'(rowAddr + (interlace ? 2'h2 : 2'h1));
    assign lineStart   = bufAddr + 32'(rowAddr) * strideQ;
    assign col         = CW'(pixIdx - startPix);
    assign colBytes    = mono ? 32'(col) : 32'(col) * 32'(BYTES_RGB);
    assign lineRel     = CW'(lineCntQ - startLine);
    assign frameRow    = interlace ? {lineRel[CW-2:0], fieldQ} : lineRel;

    always_ff @(posedge clk) begin
        if (rst) begin
            bufIdxQ   <= 4'h0;
            rowQ      <= '0;
            frameCntQ <= 16'h0000;
        end else if (stateQ == ST_SWITCH) begin
            bufIdxQ   <= bufIdxNext;
            rowQ      <= '0;
            frameCntQ <= frameCntQ + 1'b1;
        end else if (vLead && stateQ == ST_CAPT) begin
            rowQ <= '0;
        end else if (lineDone && !frameDone) begin // Frame end moves buffer once
            if (rowAddrNext >= linesPerBuf) begin
                rowQ    <= '0;
                bufIdxQ <= bufIdxNext;
            end else begin
                rowQ <= rowQ + 1'b1;
            end
        end
    end

    // Linear write pointer, restarted at each frame start
    always_ff @(posedge clk) begin
        if (rst) begin
            linAddrQ <= 32'h0000_0000;
        end else if (startFrame) begin
            linAddrQ <= bufAddr;
        end else if (pixWr) begin
            linAddrQ <= linAddrQ + (mono ? 32'(BYTES_GREY) : 32'(BYTES_RGB));
        end
    end

    // ------------------------------------------------------------------
    // DMA output stage
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            dmaValidQ  <= 1'b0;
            dmaAddrQ   <= 32'h0000_0000;
            dmaDataQ   <= 24'h00_0000;
            dmaBytesQ  <= 2'h0;
            dmaInCropQ <= 1'b0;
        end else begin
            dmaValidQ <= pixWr;
            if (pixWr) begin
                dmaAddrQ <= linear ? linAddrQ : lineStart + colBytes;
                if (mono) begin
                    dmaDataQ  <= {16'h0000, greenQ};
                    dmaBytesQ <= BYTES_GREY;
                end else begin
                    dmaDataQ  <= {blueQ, greenQ, redQ};
                    dmaBytesQ <= BYTES_RGB;
                end
                dmaInCropQ <= (col >= cropX) && (col < CW'(cropX + cropW)) &&
                              (frameRow >= cropY) && (frameRow < CW'(cropY + cropH));
            end
        end
    end

    assign dat_o      = datQ;
    assign ack_o      = ackQ;
    assign muxSel0    = muxQ[1:0];
    assign muxSel1    = muxQ[3:2];
    assign activeChan = activeChanQ;
    assign dmaValid   = dmaValidQ;
    assign dmaAddr    = dmaAddrQ;
    assign dmaData    = dmaDataQ;
    assign dmaBytes   = dmaBytesQ;
    assign dmaInCrop  = dmaInCropQ;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sFrameEnd;
        stateQ == ST_SWITCH;
    endsequence

    sequence sChanSwap;
        sFrameEnd ##0 (ppChan && chanEn[~activeChanQ]);
    endsequence

    AST_ENABLE_GATES: assert property (dmaValidQ |-> $past(capOk))
        else $error("pixel written while channel or capture disabled");
    AST_PIX_ZERO: assert property (hLead |=> pixCntQ == '0)
        else $error("pixel counter not zeroed at hsync edge");
    AST_LINE_ZERO: assert property (vLead |=> lineCntQ == '0)
        else $error("line counter not zeroed at vsync edge");
    AST_LINE_RANGE: assert property (dmaValidQ |->
        $past(lineCntQ) >= $past(startLine) && $past(lineCntQ) <= $past(endLine))
        else $error("write outside line window");
    AST_FIRST_PIX: assert property ((stateQ == ST_CAPT) && capOk && inLine &&
        pixIdx == startPix && roiWidth != '0 |=> dmaValidQ)
        else $error("start pixel not captured");
    AST_MANUAL_POL: assert property (!autoPol |-> hPol == ctrlQ[CTRL_HSHIGH] &&
        vPol != ctrlQ[CTRL_VSLOW])
        else $error("manual polarity sense wrong");
    AST_MONO: assert property (dmaValidQ && $past(mono) |->
        dmaBytesQ == BYTES_GREY && dmaDataQ[23:8] == 16'h0000 &&
        dmaDataQ[7:0] == $past(greenQ))
        else $error("monochrome pixel packing wrong");
    AST_COLOUR: assert property (dmaValidQ && !$past(mono) |->
        dmaDataQ == {$past(blueQ), $past(greenQ), $past(redQ)})
        else $error("colour byte order wrong");
    AST_RING_WRAP: assert property (sFrameEnd ##0 (bufIdxQ + 1'b1 >= ringCount)
        |=> bufIdxQ == 4'h0)
        else $error("buffer ring did not wrap");
    AST_SWAP: assert property (sChanSwap |=> activeChanQ != $past(activeChanQ))
        else $error("ping-pong did not change channel");
    AST_HOLD_CHAN: assert property ((stateQ == ST_WAIT) && chanEn[activeChanQ]
        |=> $stable(activeChanQ))
        else $error("channel skipped while waiting for a frame");
    AST_MUX_STEP: assert property (sFrameEnd ##0 (ppMux &&
        muxQ[{activeChanQ, 1'b0} +: 2] == MUX_A)
        |=> muxQ[{$past(activeChanQ), 1'b0} +: 2] == MUX_B)
        else $error("mux setting not stepped");

endmodule // vrc_capture

// ---- vrc_pkg.sv ----
// Register map, field positions, reset values and types of the video capture channel
package vrc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_HROI   = 8'h04;
    localparam logic [7:0] REG_VROI   = 8'h08;
    localparam logic [7:0] REG_RING   = 8'h0C;
    localparam logic [7:0] REG_BASE   = 8'h10;
    localparam logic [7:0] REG_STRIDE = 8'h14;
    localparam logic [7:0] REG_CROPXY = 8'h18;
    localparam logic [7:0] REG_CROPWH = 8'h1C;
    localparam logic [7:0] REG_MUX    = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_EN0        = 0;
    localparam int CTRL_CAPEN      = 2;
    localparam int CTRL_AUTOPOL    = 3;
    localparam int CTRL_HSHIGH     = 4;
    localparam int CTRL_VSLOW      = 5;
    localparam int CTRL_INTERLACE  = 6;
    localparam int CTRL_MONO       = 7;
    localparam int CTRL_LINEAR     = 8;
    localparam int CTRL_PPCHAN     = 9;
    localparam int CTRL_PPMUX      = 10;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_RST   = 32'h0000_001F;
    localparam logic [31:0] HROI_RST   = 32'h0500_0166;
    localparam logic [31:0] VROI_RST   = 32'h0413_0014;
    localparam logic [31:0] RING_RST   = 32'h0400_0004;
    localparam logic [31:0] BASE_RST   = 32'h0000_0000;
    localparam logic [31:0] STRIDE_RST = 32'h0000_0F00;
    localparam logic [31:0] CROPXY_RST = 32'h0000_0000;
    localparam logic [31:0] CROPWH_RST = 32'h0400_0500;

    // ------------------------------------------------------------------
    // Input multiplexer codes and pixel sizes
    // ------------------------------------------------------------------
    localparam logic [1:0] MUX_A   = 2'h0;
    localparam logic [1:0] MUX_B   = 2'h1;
    localparam logic [1:0] MUX_OFF = 2'h2;
    localparam logic [1:0] BYTES_GREY = 2'h1;
    localparam logic [1:0] BYTES_RGB  = 2'h3;

    // Capture sequencer states
    typedef enum logic [2:0] {
        ST_WAIT   = 3'b001,
        ST_CAPT   = 3'b010,
        ST_SWITCH = 3'b100
    } vrc_state_t;

endpackage

// ---- vrc_digitizer.sv ----
// Behavioural digitizer model driving one raster of pixels and syncs
`timescale 1ns/1ps
module vrc_digitizer #(
    parameter int PPL = 16,
    parameter int LPF = 6
) (
    // System
    input  wire logic       clk,
    input  wire logic       rst,
    // Video out
    output logic      [7:0] red,
    output logic      [7:0] green,
    output logic      [7:0] blue,
    output logic            hsync,
    output logic            vsync
);
    int pixQ;
    int lineQ;
    // Raster position; colours follow the column so pixel order errors show
    always_ff @(posedge clk) begin
        pixQ <= (rst || pixQ == PPL - 1) ? 0 : pixQ + 1;
        if (rst) lineQ <= 0;
        else if (pixQ == PPL - 1) lineQ <= (lineQ == LPF - 1) ? 0 : lineQ + 1;
    end
    assign red   = 8'(pixQ);
    assign green = 8'(pixQ) + 8'h40;
    assign blue  = 8'(pixQ) + 8'h80;
    // Short high pulses, so the auto detector must call both active high
    assign hsync = (pixQ == 0);
    assign vsync = (lineQ == 0);
endmodule // vrc_digitizer

// ---- video_roi_capture_channel_tb.sv ----
// Self-checking bench for the video capture channel
`timescale 1ns/1ps
module video_roi_capture_channel_tb;
    import vrc_pkg::*;
    logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, cntEn = 0;
    logic [7:0]  adr = 0, r0, g0, b0, r1, g1, b1;
    logic [31:0] wDat = 0, rDat, dOut, dmaAddr, a0, a1, aL;
    logic        hs0, vs0, hs1, vs1, ack, dmaValid, dmaInCrop, activeChan, cS;
    logic [1:0]  mux0, mux1, dmaBytes, by0, mS;
    logic [23:0] dmaData, d0;
    int          errors = 0, compares = 0, pixCnt = 0, cycles = 0, cropCnt = 0;
    vrc_capture vrc_capture_inst (.clk, .rst, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wDat), .dat_o(dOut), .ack_o(ack), .ch0Red(r0), .ch0Green(g0),
        .ch0Blue(b0), .ch0Hsync(hs0), .ch0Vsync(vs0), .ch1Red(r1), .ch1Green(g1), .ch1Blue(b1),
        .ch1Hsync(hs1), .ch1Vsync(vs1), .muxSel0(mux0), .muxSel1(mux1), .activeChan,
        .dmaValid, .dmaAddr, .dmaData, .dmaBytes, .dmaInCrop);
    vrc_digitizer vrc_digitizer_inst0 (.clk, .rst, .red(r0), .green(g0), .blue(b0),
        .hsync(hs0), .vsync(vs0));
    vrc_digitizer vrc_digitizer_inst1 (.clk, .rst, .red(r1), .green(g1), .blue(b1),
        .hsync(hs1), .vsync(vs1));
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle; held until ack is sampled, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wDat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        rDat = dOut;
        cyc <= 0;
        stb <= 0;
        if (n == 40) begin
            errors++;
            $display("[FAIL] %0t no bus answer", $time);
        end
    endtask
    // Capture monitor: counts pixels, keeps the first two of the window
    always @(posedge clk) begin
        if (cntEn && dmaValid === 1'b1) begin
            if (pixCnt == 0) begin
                a0 <= dmaAddr;
                d0 <= dmaData;
                by0 <= dmaBytes;
            end
            if (pixCnt == 1) a1 <= dmaAddr;
            aL <= dmaAddr;
            if (dmaInCrop === 1'b1) cropCnt <= cropCnt + 1;
            pixCnt <= pixCnt + 1;
        end
        // Channel and mux as they stood when the window opened
        if (!cntEn) begin
            mS <= mux0;
            cS <= activeChan;
        end
    end
    // Three whole frames after capture settled; ROI is 4 pixels by 2 lines
    task automatic frames(input logic [31:0] ctrl, input int n, input logic [23:0] d,
                          input logic [1:0] by);
        wb(1, REG_CTRL, ctrl);
        repeat (2) @(posedge clk iff (vs0 && hs0));
        pixCnt <= 0;
        cropCnt <= 0;
        cntEn <= 1;
        repeat (288) @(posedge clk);
        cntEn <= 0;
        @(posedge clk);
        chk(pixCnt, n);
        if (n > 0) begin
            chk(d0, d);
            chk(by0, by);
            chk(a1 - a0, 32'(by));
        end
    endtask
    // Two-buffer ring at 0x2000, stride 0x100, 2x1 host crop inside the 4x2 window
    task automatic layout(input logic [31:0] ctrl, input logic [31:0] span);
        wb(1, REG_BASE, 32'h2000);
        wb(1, REG_STRIDE, 32'h100);
        wb(1, REG_RING, 32'h0010_0002);
        wb(1, REG_CROPXY, 32'h0001_0001);
        wb(1, REG_CROPWH, 32'h0001_0002);
        frames(ctrl, 24, 24'h854505, BYTES_RGB);
        chk(a0 & 32'hFFFF_EFFF, 32'h2000);
        chk(aL - a0, span);
        chk(cropCnt, 6);
    endtask
    // Three frame ends fall in the window, so ping-pong leaves its start state flipped
    task automatic pingpong(input logic [31:0] ctrl, input logic chanFlip, input logic muxFlip);
        wb(1, REG_MUX, 32'h8);
        frames(ctrl, 24, 24'h854505, BYTES_RGB);
        chk(activeChan, cS ^ chanFlip);
        chk(mux0, muxFlip ? ((mS == MUX_A) ? MUX_B : MUX_A) : mS);
        chk(mux1, MUX_OFF);
        wb(0, REG_MUX, 0);
        chk(rDat, {28'h000_0000, MUX_OFF, mux0});
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        wb(0, REG_CTRL, 0);
        chk(rDat, CTRL_RST);
        wb(0, 8'h3C, 0);
        chk(rDat, 0);
        wb(1, REG_HROI, 32'h0004_0005);
        wb(1, REG_VROI, 32'h0003_0002);
        wb(0, REG_HROI, 0);
        chk(rDat, 32'h0004_0005);
        frames(32'h15, 24, 24'h854505, BYTES_RGB);
        frames(32'h2D, 24, 24'h854505, BYTES_RGB);
        frames(32'h95, 24, 24'h000045, BYTES_GREY);
        frames(32'h11, 0, 0, 0);
        frames(32'h14, 0, 0, 0);
        frames(32'h15, 24, 24'h854505, BYTES_RGB);
        layout(32'h15, 32'h109);
        layout(32'h115, 32'h15);
        pingpong(32'h415, 0, 1);
        pingpong(32'h217, 1, 0);
        report_and_stop();
    end
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
endmodule // video_roi_capture_channel_tb
